/* cxpum_pkg.sv */
// package: register map, field layout, reset values and carriers of the error monitor
package cxpum_pkg;

  // ==========================================================================
  // sizes
  localparam int NUM_LINKS = 4;
  localparam int CNT_W = 12;
  localparam int FLAG_W = 6;
  localparam int IRQ_W = 5;

  // ==========================================================================
  // register byte offsets
  localparam logic [4:0] OFS_LINK_SEL = 5'h00;
  localparam logic [4:0] OFS_HDR_TRL_CNT = 5'h04;
  localparam logic [4:0] OFS_LINK_FLAGS = 5'h08;
  localparam logic [4:0] OFS_CORR_CNT = 5'h0C;
  localparam logic [4:0] OFS_UNCORR_CNT = 5'h10;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h14;
  localparam logic [4:0] OFS_IRQ_CLR = 5'h18;
  localparam logic [4:0] OFS_IRQ_EN = 5'h1C;

  // ==========================================================================
  // field positions
  localparam int POS_OVF = 12;
  localparam int POS_MULTI_BYTE = 2;
  localparam int IRQ_HDR_TRL = 0;
  localparam int IRQ_PKT_FLAG = 1;
  localparam int IRQ_SINGLE_CORR = 2;
  localparam int IRQ_MULTI_BYTE = 3;
  localparam int IRQ_OVF = 4;

  // ==========================================================================
  // values after reset, and the counter top value
  localparam logic [CNT_W-1:0] CNT_RST = 12'h000;
  localparam logic [CNT_W-1:0] CNT_MAX = 12'hFFF;
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // ==========================================================================
  // per-link events from the receive path, one-cycle pulses
  typedef struct packed {
    logic hdrTrlUncorr;
    logic heartbeat;
    logic linkTest;
    logic controlAck;
    logic stream;
    logic triggerAck;
    logic trigger;
  } cxpum_link_ev_s;

  // device-wide stream events, one-cycle pulses
  typedef struct packed {
    logic singleByteCorr;
    logic multiByteUncorr;
  } cxpum_stream_ev_s;

endpackage

/* cxpum_monitor.sv */
// file: uncorrected receive error monitor with avalon-mm register slave
`timescale 1ns/100ps
// Function
// - keep read-only count of single-byte corrections in stream packets, 0 to 4095
// - per link, 12-bit count of uncorrected header and trailer errors
// - on that counter's overflow set bit 12, while the count holds at 4095
// - per link flag: uncorrectable error seen in trigger packet
// - per link flag: uncorrectable error seen in trigger acknowledge packet
// - per link flag: uncorrected error seen in stream packet
// - per link flag: uncorrectable error seen in control acknowledge packet
// - per link flag: uncorrectable error seen in link test packet
// - per link flag: uncorrectable error seen in heartbeat packet
// - keep read-only count of uncorrected receive errors, 0 to 4095
// - bit 2 of uncorrected count value flags multi-byte stream errors
module cxpum_monitor #(
  parameter int NUM_LINKS = cxpum_pkg::NUM_LINKS
) (
  input wire logic mclk,
  input wire logic rst,
  // receive path events
  input wire cxpum_pkg::cxpum_link_ev_s [NUM_LINKS-1:0] linkEv,
  input wire cxpum_pkg::cxpum_stream_ev_s streamEv,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // interrupt
  output logic irq
);

  localparam int CW = cxpum_pkg::CNT_W;
  localparam int FW = cxpum_pkg::FLAG_W;
  localparam int IW = cxpum_pkg::IRQ_W;

  // ==========================================================================
  // helpers

  // saturating increment, reports whether the count was already at the top
  function automatic logic [CW:0] satInc(input logic [CW-1:0] cnt, input logic ev);
    logic [CW:0] res;
    res = {1'b0, cnt};
    if (ev) begin
      if (cnt == cxpum_pkg::CNT_MAX) begin
        res = {1'b1, cnt};
      end else begin
        res = {1'b0, cnt + {{(CW-1){1'b0}}, 1'b1}};
      end
    end
    return res;
  endfunction

  // word match of a byte address against a register offset
  function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
    return addr[4:2] == ofs[4:2];
  endfunction

  // ==========================================================================
  // declarations
  logic [CW-1:0] hdrCnt_q [NUM_LINKS];
  logic [NUM_LINKS-1:0] hdrOvf_q;
  logic [NUM_LINKS-1:0] hdrOvfEv;
  logic [FW-1:0] flags_q [NUM_LINKS];
  logic [NUM_LINKS-1:0] anyFlagEv;
  logic [NUM_LINKS-1:0] anyHdrEv;
  logic [CW-1:0] corrCnt_q;
  logic [CW-1:0] uncorrCnt_q;
  logic multiByte_q;
  logic [CW:0] corrNext;
  logic [CW:0] uncorrNext;
  logic uncorrEv;
  logic [1:0] linkSel_q;
  logic [IW-1:0] irqStat_q;
  logic [IW-1:0] irqEn_q;
  logic [IW-1:0] irqSet;
  logic [IW-1:0] irqClr;
  logic waitReq_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic irq_q;
  logic reqTake;
  logic wrTake;
  logic [31:0] wmask;

  // ==========================================================================
  // per-link counters and flags
  for (genvar l = 0; l < NUM_LINKS; l++) begin : g_link
    logic [CW:0] hdrNext;

    assign hdrNext = satInc(hdrCnt_q[l], linkEv[l].hdrTrlUncorr);
    assign hdrOvfEv[l] = hdrNext[CW];
    assign anyHdrEv[l] = linkEv[l].hdrTrlUncorr;

    // header and trailer error count, saturating
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        hdrCnt_q[l] <= cxpum_pkg::CNT_RST;
      end else begin
        hdrCnt_q[l] <= hdrNext[CW-1:0];
      end
    end

    // sticky overflow bit above the count
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        hdrOvf_q[l] <= 1'b0;
      end else if (hdrNext[CW]) begin
        hdrOvf_q[l] <= 1'b1;
      end
    end

    // sticky per-packet-type flags
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        flags_q[l] <= '0;
      end else begin
        flags_q[l][0] <= flags_q[l][0] | linkEv[l].trigger;
        flags_q[l][1] <= flags_q[l][1] | linkEv[l].triggerAck;
        flags_q[l][2] <= flags_q[l][2] | linkEv[l].stream;
        flags_q[l][3] <= flags_q[l][3] | linkEv[l].controlAck;
        flags_q[l][4] <= flags_q[l][4] | linkEv[l].linkTest;
        flags_q[l][5] <= flags_q[l][5] | linkEv[l].heartbeat;
      end
    end

    assign anyFlagEv[l] = linkEv[l].trigger | linkEv[l].triggerAck | linkEv[l].stream |
                          linkEv[l].controlAck | linkEv[l].linkTest | linkEv[l].heartbeat;
  end

  // ==========================================================================
  // device-wide receive counters

  // any uncorrected error anywhere counts once per cycle
  assign uncorrEv = streamEv.multiByteUncorr | (|anyHdrEv) | (|anyFlagEv);
  assign corrNext = satInc(corrCnt_q, streamEv.singleByteCorr);
  assign uncorrNext = satInc(uncorrCnt_q, uncorrEv);

  // single-byte correction count
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      corrCnt_q <= cxpum_pkg::CNT_RST;
    end else begin
      corrCnt_q <= corrNext[CW-1:0];
    end
  end

  // uncorrected error count
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      uncorrCnt_q <= cxpum_pkg::CNT_RST;
    end else begin
      uncorrCnt_q <= uncorrNext[CW-1:0];
    end
  end

  // sticky marker of multi-byte stream errors
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      multiByte_q <= 1'b0;
    end else if (streamEv.multiByteUncorr) begin
      multiByte_q <= 1'b1;
    end
  end

  // ==========================================================================
  // bus handshake
  // waitrequest rests high; it drops for exactly one cycle per request, the
  // cycle after the request is seen, and read data stand in that same cycle

  assign reqTake = (avs_read | avs_write) & waitReq_q;
  assign wrTake = avs_write & ~waitReq_q;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // one-cycle acknowledge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      waitReq_q <= 1'b1;
    end else begin
      waitReq_q <= ~reqTake;
    end
  end

  // ==========================================================================
  // writable registers

  // link index chosen before a per-link read
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      linkSel_q <= cxpum_pkg::SEL_RST;
    end else if (wrTake && hit(avs_address, cxpum_pkg::OFS_LINK_SEL) && avs_byteenable[0]) begin
      linkSel_q <= avs_writedata[1:0];
    end
  end

  // interrupt enable
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irqEn_q <= cxpum_pkg::IRQ_RST;
    end else if (wrTake && hit(avs_address, cxpum_pkg::OFS_IRQ_EN)) begin
      irqEn_q <= (irqEn_q & ~wmask[IW-1:0]) | (avs_writedata[IW-1:0] & wmask[IW-1:0]);
    end
  end

  // ==========================================================================
  // interrupt status

  assign irqSet[cxpum_pkg::IRQ_HDR_TRL] = |anyHdrEv;
  assign irqSet[cxpum_pkg::IRQ_PKT_FLAG] = |anyFlagEv;
  assign irqSet[cxpum_pkg::IRQ_SINGLE_CORR] = streamEv.singleByteCorr;
  assign irqSet[cxpum_pkg::IRQ_MULTI_BYTE] = streamEv.multiByteUncorr;
  assign irqSet[cxpum_pkg::IRQ_OVF] = (|hdrOvfEv) | corrNext[CW] | uncorrNext[CW];

  // write one to clear
  assign irqClr = (wrTake && hit(avs_address, cxpum_pkg::OFS_IRQ_CLR)) ?
                  (avs_writedata[IW-1:0] & wmask[IW-1:0]) : cxpum_pkg::IRQ_RST;

  // sticky status, a new event beats a clear in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irqStat_q <= cxpum_pkg::IRQ_RST;
    end else begin
      irqStat_q <= (irqStat_q & ~irqClr) | irqSet;
    end
  end

  // level interrupt
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irqStat_q & irqEn_q);
    end
  end

  // ==========================================================================
  // read mux
  always_comb begin
    rdata_d = cxpum_pkg::RDATA_RST;
    if (hit(avs_address, cxpum_pkg::OFS_LINK_SEL)) begin
      rdata_d[1:0] = linkSel_q;
    end else if (hit(avs_address, cxpum_pkg::OFS_HDR_TRL_CNT)) begin
      rdata_d[CW-1:0] = hdrCnt_q[linkSel_q];
      rdata_d[cxpum_pkg::POS_OVF] = hdrOvf_q[linkSel_q];
    end else if (hit(avs_address, cxpum_pkg::OFS_LINK_FLAGS)) begin
      rdata_d[FW-1:0] = flags_q[linkSel_q];
    end else if (hit(avs_address, cxpum_pkg::OFS_CORR_CNT)) begin
      rdata_d[CW-1:0] = corrCnt_q;
    end else if (hit(avs_address, cxpum_pkg::OFS_UNCORR_CNT)) begin
      rdata_d[CW-1:0] = uncorrCnt_q;
      rdata_d[cxpum_pkg::POS_MULTI_BYTE] = uncorrCnt_q[cxpum_pkg::POS_MULTI_BYTE] |
                                           multiByte_q;
    end else if (hit(avs_address, cxpum_pkg::OFS_IRQ_STAT)) begin
      rdata_d[IW-1:0] = irqStat_q;
    end else if (hit(avs_address, cxpum_pkg::OFS_IRQ_EN)) begin
      rdata_d[IW-1:0] = irqEn_q;
    end
  end

  // read data captured when the acknowledge is set up
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_q <= cxpum_pkg::RDATA_RST;
    end else if (reqTake && avs_read) begin
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = waitReq_q;
  assign irq = irq_q;

endmodule

/* cxpum_monitor_checker.sv */
// checker: bus handshake, field widths and interrupt causes
`timescale 1ns/100ps
module cxpum_monitor_checker #(
  parameter int NUM_LINKS = 4
) (
  input wire logic mclk,
  input wire logic rst,
  input wire cxpum_pkg::cxpum_link_ev_s [NUM_LINKS-1:0] linkEv,
  input wire cxpum_pkg::cxpum_stream_ev_s streamEv,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq
);
  // ====
  // helpers
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic ev;
  logic rdAck;
  logic wrAck;
  assign ev = (|linkEv) || (|streamEv);
  assign rdAck = !avs_waitrequest && avs_read;
  assign wrAck = !avs_waitrequest && avs_write;
  // ====
  // properties
  property p_ack; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("request not answered in one cycle");
  property p_ack_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_ack_one: assert property (p_ack_one) else $error("answer longer than one cycle");
  property p_idle; !avs_read && !avs_write |=> avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_rd_hold; $changed(avs_readdata) |-> rdAck; endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved outside a read");
  property p_rst; disable iff (1'b0) rst |-> avs_waitrequest && !irq && avs_readdata == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not at reset value");
  property p_irq_rise; $rose(irq) |-> $past(ev) || $past(ev, 2) || $past(ev, 3) || $past(wrAck)
    || $past(wrAck, 2); endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("interrupt without cause");
  property p_irq_fall; $fell(irq) |-> $past(wrAck) || $past(wrAck, 2); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped by itself");
  property p_sel; rdAck && avs_address[4:2] == 3'h0 |-> avs_readdata[31:2] == 30'h0; endproperty
  a_sel: assert property (p_sel) else $error("link index wider than two bits");
  property p_hdr; rdAck && avs_address[4:2] == 3'h1 |-> avs_readdata[31:13] == 19'h0; endproperty
  a_hdr: assert property (p_hdr) else $error("link count wider than 13 bits");
  property p_flg; rdAck && avs_address[4:2] == 3'h2 |-> avs_readdata[31:6] == 26'h0; endproperty
  a_flg: assert property (p_flg) else $error("flag word wider than 6 bits");
  property p_cnt; rdAck && avs_address[4:3] != 2'h0 && avs_address[4:2] < 3'h5
    |-> avs_readdata[31:12] == 20'h0; endproperty
  a_cnt: assert property (p_cnt) else $error("device count wider than 12 bits");
endmodule
bind cxpum_monitor cxpum_monitor_checker #(.NUM_LINKS(NUM_LINKS)) u_cxpum_monitor_checker (
  .mclk(mclk), .rst(rst), .linkEv(linkEv), .streamEv(streamEv), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq(irq));

/* cxpum_camera.sv */
// partner: camera side sending error events on four links
`timescale 1ns/100ps
module cxpum_camera (
  input wire logic mclk,
  output cxpum_pkg::cxpum_link_ev_s [3:0] linkEv,
  output cxpum_pkg::cxpum_stream_ev_s streamEv
);
  // ====
  // idle lines
  initial begin
    linkEv = '0;
    streamEv = '0;
  end
  // n one-cycle events, back to back or spaced by gap plus one idle cycles
  task automatic send(input int lnk, input logic [6:0] bits, input logic [1:0] sev,
    input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      linkEv[lnk] <= bits;
      streamEv <= sev;
      if (gap > 0 || i == n - 1) begin
        @(posedge mclk);
        linkEv <= '0;
        streamEv <= '0;
        repeat (gap) @(posedge mclk);
      end
    end
  endtask
endmodule

/* tb_top.sv */
// testbench: register reads against a counting model of the monitor
`timescale 1ns/100ps
module tb_top;
  // ====
  // signals and model state
  logic mclk = 1'b0;
  logic rst;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  cxpum_pkg::cxpum_link_ev_s [3:0] linkEv;
  cxpum_pkg::cxpum_stream_ev_s streamEv;
  int errorCnt = 0;
  int cmpCount = 0;
  int seed = 7;
  int hdr[4] = '{default: 0};
  int corr = 0;
  int unc = 0;
  logic [5:0] flg[4] = '{default: 6'h00};
  logic ovf[4] = '{default: 1'b0};
  logic multi = 1'b0;
  always #50 mclk = ~mclk;
  cxpum_camera u_cxpum_camera (.mclk(mclk), .linkEv(linkEv), .streamEv(streamEv));
  cxpum_monitor u_cxpum_monitor (.mclk(mclk), .rst(rst), .linkEv(linkEv), .streamEv(streamEv),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
  // ====
  // tasks
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      errorCnt++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
    input logic [3:0] be, output logic [31:0] q);
    @(posedge mclk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input string n, input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hF, q);
    chk(n, q, e);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask
  // send events and advance the model
  task automatic fire(input int l, input logic [6:0] b, input logic [1:0] s, input int n,
    input int g);
    u_cxpum_camera.send(l, b, s, n, g);
    repeat (n) begin
      if (b[6] && hdr[l] == 4095) ovf[l] = 1'b1;
      else if (b[6]) hdr[l]++;
      flg[l] |= b[5:0];
      if (s[1] && corr < 4095) corr++;
      if ((b != 7'h00 || s[0]) && unc < 4095) unc++;
      if (s[0]) multi = 1'b1;
    end
    repeat (4) @(posedge mclk);
  endtask
  task automatic checkLink(input int l);
    wr(cxpum_pkg::OFS_LINK_SEL, 32'(l), 4'hF);
    rd("sel", cxpum_pkg::OFS_LINK_SEL, 32'(l));
    rd("hdr", cxpum_pkg::OFS_HDR_TRL_CNT, 32'({ovf[l], hdr[l][11:0]}));
    rd("flags", cxpum_pkg::OFS_LINK_FLAGS, 32'(flg[l]));
  endtask
  task automatic checkDev();
    rd("corr", cxpum_pkg::OFS_CORR_CNT, 32'(corr));
    rd("uncorr", cxpum_pkg::OFS_UNCORR_CNT, 32'(unc) | (32'(multi) << 2));
  endtask
  task automatic reportAndStop();
    $display("comparisons %0d mismatches %0d", cmpCount, errorCnt);
    if (errorCnt == 0 && cmpCount > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ====
  // watchdog
  initial begin
    repeat (30000) @(posedge mclk);
    errorCnt++;
    reportAndStop();
  end
  // ====
  // main sequence
  initial begin
    rst = 1'b1; // rising from unknown gives the asynchronous reset its edge
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) if (i != 6) rd("reset", 5'(i * 4), 32'h0);
    // masked event, then enabled event, then clear
    wr(cxpum_pkg::OFS_IRQ_EN, 32'(1 << cxpum_pkg::IRQ_SINGLE_CORR), 4'hF);
    fire(0, 7'h01, 2'b00, 1, 0);
    chk("irq masked", 32'(irq), 32'h0);
    rd("status", cxpum_pkg::OFS_IRQ_STAT, 32'(1 << cxpum_pkg::IRQ_PKT_FLAG));
    fire(2, 7'h00, 2'b10, 1, 0);
    chk("irq", 32'(irq), 32'h1);
    wr(cxpum_pkg::OFS_IRQ_CLR, 32'h1F, 4'hF);
    rd("status clr", cxpum_pkg::OFS_IRQ_STAT, 32'h0);
    chk("irq clr", 32'(irq), 32'h0);
    // read-only write and masked index write are ignored
    wr(cxpum_pkg::OFS_CORR_CNT, 32'h0000_0ABC, 4'hF);
    wr(cxpum_pkg::OFS_LINK_SEL, 32'h3, 4'hE);
    rd("sel be", cxpum_pkg::OFS_LINK_SEL, 32'h0);
    checkDev();
    // every packet kind on every link, then random traffic
    for (int l = 0; l < 4; l++) for (int k = 0; k < 7; k++) fire(l, 7'(1 << k), 2'b00, 1 + k % 2, k % 2);
    repeat (16) fire($random(seed) & 3, 7'($random(seed)), 2'($random(seed)),
      1 + ($random(seed) & 7), $random(seed) & 1);
    for (int l = 0; l < 4; l++) checkLink(l);
    checkDev();
    // saturation and overflow
    fire(1, 7'h40, 2'b11, 4100, 0);
    checkLink(1);
    checkDev();
    reportAndStop();
  end
endmodule
